// *** verilog/dpc_pkg.sv ***
// Shared constants and types for the two-wire pot slave and its bus master.
// Assumes a 25 MHz system clock on both ends.
package dpc_pkg;

   // ****************************************
   // Timing
   // ****************************************
   localparam int unsigned CLK_HZ       = 25_000_000;
   localparam int unsigned CLK_PER_US   = CLK_HZ / 1_000_000;
   localparam int unsigned WRITE_US     = 5000;
   localparam int unsigned WRITE_CYC    = WRITE_US * CLK_PER_US;
   localparam int unsigned PURST_US     = 50000;
   localparam int unsigned PURST_CYC    = PURST_US * CLK_PER_US;
   localparam int unsigned QUARTER_CYC  = 4;

   // ****************************************
   // Slave address and instruction fields
   // ****************************************
   localparam logic [3:0] DEV_TYPE      = 4'ha;
   localparam logic [2:0] TGT_EEPROM    = 3'h0;
   localparam logic [2:0] TGT_CSR       = 3'h2;
   localparam logic [2:0] TGT_POT       = 3'h7;
   localparam logic [1:0] POT_RESERVED  = 2'h3;
   localparam int unsigned INSTR_TOP_BIT = 7;

   // ****************************************
   // Wiper limits and reset values
   // ****************************************
   localparam logic [7:0] POT0_MAX      = 8'h3f;
   localparam logic [7:0] POT1_MAX      = 8'h63;
   localparam logic [7:0] POT2_MAX      = 8'hff;
   localparam logic [7:0] POT0_INIT     = 8'h3f;
   localparam logic [7:0] POT1_INIT     = 8'h00;
   localparam logic [7:0] POT2_INIT     = 8'hff;
   localparam logic [7:0] NV_RESET      = 8'h00;
   localparam logic [7:0] EE_IDLE_DATA  = 8'hff;

   // ****************************************
   // Control/status register layout
   // ****************************************
   localparam logic [7:0] CSR_RESET     = 8'h00;
   localparam int unsigned CSR_WEL_BIT  = 0;
   localparam int unsigned CSR_POR_LSB  = 1;

   // ****************************************
   // Host command registers (Wishbone)
   // ****************************************
   localparam logic [3:0] ADR_CMD       = 4'h0;
   localparam logic [3:0] ADR_TX        = 4'h4;
   localparam logic [3:0] ADR_STAT      = 4'h8;
   localparam int unsigned CMD_NACK_BIT = 2;
   localparam int unsigned STAT_BUSY_BIT = 0;
   localparam int unsigned STAT_ACK_BIT = 1;
   localparam int unsigned STAT_RX_LSB  = 8;

   typedef enum logic [1:0] {OP_START, OP_STOP, OP_WRITE, OP_READ} dpc_op_e;
   typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_TXACK, ST_IGNORE} dpc_dev_e;
   typedef enum logic {HS_IDLE, HS_RUN} dpc_host_e;

endpackage

// *** verilog/dpc_link_if.sv ***
// Two-wire link between the bus master end and the pot slave end.
// SCL is driven by the master; SDA is open drain, resolved here.
`timescale 1ns/100ps
interface dpc_link_if;
   logic scl;
   logic sdaHostOut;
   logic sdaHostOeN;
   logic sdaDevOut;
   logic sdaDevOeN;
   logic sda;

   // Wired-AND with pull-up
   assign sda = (sdaHostOeN | sdaHostOut) & (sdaDevOeN | sdaDevOut);

   modport host (output scl, output sdaHostOut, output sdaHostOeN, input sda);
   modport dev  (input scl, input sda, output sdaDevOut, output sdaDevOeN);
endinterface

// *** verilog/dpc_pot_slave.sv ***
// Two-wire slave: address decode, control register and three wiper registers.
// Assumes a master on the link interface and a supply-good level input.
`timescale 1ns/100ps

// Summary of operation
// - Master sends slave address after every START
// - Respond only to device type 1010
// - Target bits: 000 array, 010 control, 111 pots
// - Address LSB 1 reads, 0 writes
// - Pot or array write needs latch set
// - Nonvolatile write after STOP starts busy cycle
// - Withhold address acknowledge while busy
// - Master polls address until acknowledged
// - One tap switch per wiper, two for one cycle after a wiper change
// - Wipers recalled from nonvolatile store at power-up
// - Pre-recall wipers are 63, 0, 255
// - New tap enabled before old disabled
// - Recall after supply good for programmed time
// - Write type 1 updates wiper and store
// - Write type 0 updates wiper only
// - Pot write is address, instruction, data
// - Pot read is random-read sequence
// - Instruction decoded for pots; select and type
// - Write type ignored on reads
// - Reserved pot select is not acknowledged
// - Oversize data clamps to highest tap
module dpc_pot_slave
   import dpc_pkg::*;
#(
   parameter int unsigned WRITE_CYC_P = WRITE_CYC,
   parameter int unsigned PURST_CYC_P = PURST_CYC
) (
   // Clock and reset
   input  wire logic         clk_sys,
   input  wire logic         rst,
   // Link
   dpc_link_if.dev           link,
   // Supply monitor
   input  wire logic         supplyOk,
   // Tap switch enables
   output logic [63:0]       tapEn0,
   output logic [99:0]       tapEn1,
   output logic [255:0]      tapEn2,
   // Status
   output logic              writeBusy
);

   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic [7:0] potMax(input int idx);
      return (idx == 0) ? POT0_MAX : (idx == 1) ? POT1_MAX : POT2_MAX;
   endfunction

   function automatic logic [7:0] potInit(input int idx);
      return (idx == 0) ? POT0_INIT : (idx == 1) ? POT1_INIT : POT2_INIT;
   endfunction

   function automatic logic [255:0] oneHot(input logic [7:0] pos);
      logic [255:0] v;
      v = '0;
      v[pos] = 1'b1;
      return v;
   endfunction

   function automatic logic validTgt(input logic [2:0] t);
      return (t == TGT_EEPROM) || (t == TGT_CSR) || (t == TGT_POT);
   endfunction

   // ****************************************
   // Input synchronisers and bus conditions
   // ****************************************
   logic [1:0]   sclSync_ff;
   logic [1:0]   sdaSync_ff;
   logic [1:0]   supSync_ff;
   logic         sclPrev_ff;
   logic         sdaPrev_ff;
   logic         sclS;
   logic         sdaS;
   logic         supS;
   logic         sclRise;
   logic         sclFall;
   logic         startCond;
   logic         stopCond;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         sclSync_ff <= 2'h3;
         sdaSync_ff <= 2'h3;
         supSync_ff <= 2'h0;
         sclPrev_ff <= 1'b1;
         sdaPrev_ff <= 1'b1;
      end else begin
         sclSync_ff <= {sclSync_ff[0], link.scl};
         sdaSync_ff <= {sdaSync_ff[0], link.sda};
         supSync_ff <= {supSync_ff[0], supplyOk};
         sclPrev_ff <= sclSync_ff[1];
         sdaPrev_ff <= sdaSync_ff[1];
      end
   end

   assign sclS      = sclSync_ff[1];
   assign sdaS      = sdaSync_ff[1];
   assign supS      = supSync_ff[1];
   assign sclRise   = sclS & ~sclPrev_ff;
   assign sclFall   = ~sclS & sclPrev_ff;
   assign startCond = sclS & sclPrev_ff & sdaPrev_ff & ~sdaS;
   assign stopCond  = sclS & sclPrev_ff & ~sdaPrev_ff & sdaS;

   // ****************************************
   // Protocol state
   // ****************************************
   dpc_dev_e     state_ff;
   logic [3:0]   bitCnt_ff;
   logic [1:0]   byteIdx_ff;
   logic [6:0]   rxSh_ff;
   logic [7:0]   txSh_ff;
   logic [2:0]   tgt_ff;
   logic         dirRead_ff;
   logic         ackPend_ff;
   logic         ackArmed_ff;
   logic         mAck_ff;
   logic         sdaDrv_ff;
   logic [1:0]   potSel_ff;
   logic         wt_ff;
   logic         nvPend_ff;
   logic [7:0]   csr_ff;
   logic [31:0]  busyCnt_ff;
   logic [7:0]   wiper_ff [3];
   logic [7:0]   nv_ff [3];
   logic [7:0]   txByte;
   logic [7:0]   rxByte;
   logic         byteDone;
   logic         ackOk;
   logic         instrTake;
   logic         potData;
   logic         csrData;
   logic         busy;
   logic         write_enable_latch;
   logic         recallNow;

   assign rxByte    = {rxSh_ff, sdaS};
   assign byteDone  = (state_ff == ST_RX) && sclRise && (bitCnt_ff == 4'h7);
   assign busy      = (busyCnt_ff != '0);
   assign write_enable_latch       = csr_ff[CSR_WEL_BIT];
   assign instrTake = byteDone && (byteIdx_ff == 2'h1) && (tgt_ff == TGT_POT) && !dirRead_ff;
   assign potData   = byteDone && (byteIdx_ff == 2'h2) && (tgt_ff == TGT_POT) && !dirRead_ff;
   assign csrData   = byteDone && (byteIdx_ff == 2'h1) && (tgt_ff == TGT_CSR) && !dirRead_ff;

   // Acknowledge decision for the byte just received
   always_comb begin
      if (byteIdx_ff == 2'h0) begin
         ackOk = (rxByte[7:4] == DEV_TYPE) && validTgt(rxByte[3:1]) && !busy;
      end else if (tgt_ff == TGT_POT) begin
         if (byteIdx_ff == 2'h1) begin
            ackOk = (rxByte[1:0] != POT_RESERVED);
         end else begin
            ackOk = (byteIdx_ff == 2'h2);
         end
      end else begin
         ackOk = 1'b1;
      end
   end

   // Byte returned on reads
   always_comb begin
      if (tgt_ff == TGT_POT) begin
         txByte = wiper_ff[potSel_ff];
      end else if (tgt_ff == TGT_CSR) begin
         txByte = csr_ff;
      end else begin
         txByte = EE_IDLE_DATA;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state_ff    <= ST_IDLE;
         bitCnt_ff   <= '0;
         byteIdx_ff  <= '0;
         rxSh_ff     <= '0;
         txSh_ff     <= '0;
         tgt_ff      <= TGT_EEPROM;
         dirRead_ff  <= 1'b0;
         ackPend_ff  <= 1'b0;
         ackArmed_ff <= 1'b0;
         mAck_ff     <= 1'b0;
         sdaDrv_ff   <= 1'b0;
         potSel_ff   <= '0;
         wt_ff       <= 1'b0;
      end else if (startCond) begin
         state_ff   <= ST_RX;
         bitCnt_ff  <= '0;
         byteIdx_ff <= '0;
         sdaDrv_ff  <= 1'b0;
      end else if (stopCond) begin
         state_ff  <= ST_IDLE;
         sdaDrv_ff <= 1'b0;
      end else begin
         unique case (state_ff)
            ST_IDLE, ST_IGNORE: begin
               sdaDrv_ff <= 1'b0;
            end
            ST_RX: if (sclRise) begin
               rxSh_ff   <= rxByte[6:0];
               bitCnt_ff <= bitCnt_ff + 4'h1;
               if (bitCnt_ff == 4'h7) begin
                  ackPend_ff  <= ackOk;
                  ackArmed_ff <= 1'b0;
                  state_ff    <= ST_ACK;
                  if (byteIdx_ff == 2'h0) begin
                     tgt_ff     <= rxByte[3:1];
                     dirRead_ff <= rxByte[0];
                  end
                  if (instrTake && ackOk) begin
                     potSel_ff <= rxByte[1:0];
                     wt_ff     <= rxByte[INSTR_TOP_BIT];
                  end
               end
            end
            ST_ACK: if (sclFall) begin
               if (!ackArmed_ff) begin
                  ackArmed_ff <= 1'b1;
                  sdaDrv_ff   <= ackPend_ff;
               end else if (!ackPend_ff) begin
                  state_ff <= ST_IGNORE;
               end else begin
                  if (byteIdx_ff != 2'h3) begin
                     byteIdx_ff <= byteIdx_ff + 2'h1;
                  end
                  bitCnt_ff <= '0;
                  if (dirRead_ff) begin
                     txSh_ff   <= txByte;
                     sdaDrv_ff <= ~txByte[7];
                     state_ff  <= ST_TX;
                  end else begin
                     sdaDrv_ff <= 1'b0;
                     state_ff  <= ST_RX;
                  end
               end
            end
            ST_TX: if (sclRise) begin
               txSh_ff   <= {txSh_ff[6:0], 1'b0};
               bitCnt_ff <= bitCnt_ff + 4'h1;
            end else if (sclFall) begin
               if (bitCnt_ff == 4'h8) begin
                  sdaDrv_ff <= 1'b0;
                  state_ff  <= ST_TXACK;
               end else begin
                  sdaDrv_ff <= ~txSh_ff[7];
               end
            end
            ST_TXACK: if (sclRise) begin
               mAck_ff <= ~sdaS;
            end else if (sclFall) begin
               if (mAck_ff) begin
                  txSh_ff   <= txByte;
                  sdaDrv_ff <= ~txByte[7];
                  bitCnt_ff <= '0;
                  state_ff  <= ST_TX;
               end else begin
                  state_ff <= ST_IGNORE;
               end
            end
         endcase
      end
   end

   assign link.sdaDevOut = 1'b0;
   assign link.sdaDevOeN = ~sdaDrv_ff;

   // ****************************************
   // Control register, busy cycle, recall timer
   // ****************************************
   logic [31:0]  porCnt_ff;
   logic         recalled_ff;
   logic [31:0]  purstCyc;

   assign purstCyc  = PURST_CYC_P << csr_ff[CSR_POR_LSB +: 2];
   assign recallNow = supS && !recalled_ff && (porCnt_ff >= purstCyc);

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         csr_ff <= CSR_RESET;
      end else if (csrData) begin
         csr_ff <= rxByte;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst || startCond) begin
         nvPend_ff <= 1'b0;
      end else if (potData && write_enable_latch && wt_ff) begin
         nvPend_ff <= 1'b1;
      end else if (stopCond) begin
         nvPend_ff <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         busyCnt_ff <= '0;
      end else if (stopCond && nvPend_ff) begin
         busyCnt_ff <= WRITE_CYC_P;
      end else if (busy) begin
         busyCnt_ff <= busyCnt_ff - 32'h1;
      end
   end

   assign writeBusy = busy;

   always_ff @(posedge clk_sys) begin
      if (rst || !supS) begin
         porCnt_ff   <= '0;
         recalled_ff <= 1'b0;
      end else if (recallNow) begin
         recalled_ff <= 1'b1;
      end else if (!recalled_ff) begin
         porCnt_ff <= porCnt_ff + 32'h1;
      end
   end

   // ****************************************
   // Wiper registers, stores and tap decode
   // ****************************************
   logic [7:0]   prevWiper_ff [3];
   logic [255:0] tap_ff [3];

   generate
      for (genvar g = 0; g < 3; g++) begin : gPot
         always_ff @(posedge clk_sys) begin
            if (rst || !supS) begin
               wiper_ff[g] <= potInit(g);
            end else if (recallNow) begin
               wiper_ff[g] <= nv_ff[g];
            end else if (potData && write_enable_latch && (potSel_ff == 2'(g))) begin
               wiper_ff[g] <= (rxByte > potMax(g)) ? potMax(g) : rxByte;
            end
         end

         always_ff @(posedge clk_sys) begin
            if (rst) begin
               nv_ff[g] <= NV_RESET;
            end else if (stopCond && nvPend_ff && (potSel_ff == 2'(g))) begin
               nv_ff[g] <= wiper_ff[g];
            end
         end

         always_ff @(posedge clk_sys) begin
            if (rst) begin
               prevWiper_ff[g] <= potInit(g);
               tap_ff[g]       <= oneHot(potInit(g));
            end else begin
               prevWiper_ff[g] <= wiper_ff[g];
               tap_ff[g]       <= oneHot(wiper_ff[g]) | oneHot(prevWiper_ff[g]);
            end
         end
      end
   endgenerate

   assign tapEn0 = tap_ff[0][63:0];
   assign tapEn1 = tap_ff[1][99:0];
   assign tapEn2 = tap_ff[2];

endmodule

// *** verilog/dpc_bus_master.sv ***
// Two-wire bus master controlled from Wishbone command registers.
// Assumes a classic Wishbone master; SCL is divided from clk_sys.
`timescale 1ns/100ps
module dpc_bus_master
   import dpc_pkg::*;
(
   // Clock and reset
   input  wire logic         clk_sys,
   input  wire logic         rst,
   // Link
   dpc_link_if.host          link,
   // Wishbone slave
   input  wire logic         wb_cyc_i,
   input  wire logic         wb_stb_i,
   input  wire logic         wb_we_i,
   input  wire logic [3:0]   wb_adr_i,
   input  wire logic [3:0]   wb_sel_i,
   input  wire logic [31:0]  wb_dat_i,
   output logic [31:0]       wb_dat_o,
   output logic              wb_ack_o
);

   // ****************************************
   // Register access
   // ****************************************
   logic         ack_ff;
   logic [31:0]  dat_ff;
   logic [7:0]   txData_ff;
   logic [7:0]   rxData_ff;
   logic         ackSeen_ff;
   dpc_host_e    hst_ff;
   logic         wrTake;

   assign wrTake   = wb_cyc_i && wb_stb_i && wb_we_i && ack_ff && wb_sel_i[0];
   assign wb_ack_o = ack_ff;
   assign wb_dat_o = dat_ff;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         ack_ff <= 1'b0;
         dat_ff <= '0;
      end else begin
         ack_ff <= wb_cyc_i && wb_stb_i && !ack_ff;
         if (wb_cyc_i && wb_stb_i && !ack_ff) begin
            unique case (wb_adr_i)
               ADR_TX:   dat_ff <= {24'h0, txData_ff};
               ADR_STAT: dat_ff <= {16'h0, rxData_ff, 6'h0, ackSeen_ff, hst_ff == HS_RUN};
               default:  dat_ff <= '0;
            endcase
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         txData_ff <= '0;
      end else if (wrTake && (wb_adr_i == ADR_TX)) begin
         txData_ff <= wb_dat_i[7:0];
      end
   end

   // ****************************************
   // Bit engine
   // ****************************************
   logic [1:0]   sdaSync_ff;
   dpc_op_e      op_ff;
   logic [1:0]   phase_ff;
   logic [3:0]   bitCnt_ff;
   logic [7:0]   divCnt_ff;
   logic [8:0]   sh_ff;
   logic         scl_ff;
   logic         sdaOeN_ff;
   logic         tick;
   logic         isByte;
   logic         lastBit;
   dpc_op_e      newOp;

   assign newOp   = dpc_op_e'(wb_dat_i[1:0]);
   assign tick    = (divCnt_ff == 8'(QUARTER_CYC - 1));
   assign isByte  = (op_ff == OP_WRITE) || (op_ff == OP_READ);
   assign lastBit = isByte ? (bitCnt_ff == 4'h8) : 1'b1;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         sdaSync_ff <= 2'h3;
      end else begin
         sdaSync_ff <= {sdaSync_ff[0], link.sda};
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         hst_ff     <= HS_IDLE;
         op_ff      <= OP_START;
         phase_ff   <= '0;
         bitCnt_ff  <= '0;
         divCnt_ff  <= '0;
         sh_ff      <= '1;
         scl_ff     <= 1'b1;
         sdaOeN_ff  <= 1'b1;
         rxData_ff  <= '0;
         ackSeen_ff <= 1'b0;
      end else if (hst_ff == HS_IDLE) begin
         if (wrTake && (wb_adr_i == ADR_CMD)) begin
            hst_ff    <= HS_RUN;
            op_ff     <= newOp;
            phase_ff  <= '0;
            bitCnt_ff <= '0;
            divCnt_ff <= '0;
            sh_ff     <= (newOp == OP_WRITE) ? {txData_ff, 1'b1}
                                             : {8'hff, wb_dat_i[CMD_NACK_BIT]};
         end
      end else begin
         divCnt_ff <= tick ? 8'h0 : divCnt_ff + 8'h1;
         if (tick) begin
            phase_ff <= phase_ff + 2'h1;
            unique case (phase_ff)
               2'h0: sdaOeN_ff <= (op_ff == OP_START) ? 1'b1
                                : (op_ff == OP_STOP) ? 1'b0 : sh_ff[8];
               2'h1: scl_ff <= 1'b1;
               2'h2: begin
                  if (op_ff == OP_START) begin
                     sdaOeN_ff <= 1'b0;
                  end else if (op_ff == OP_STOP) begin
                     sdaOeN_ff <= 1'b1;
                  end
                  sh_ff <= {sh_ff[7:0], sdaSync_ff[1]};
               end
               2'h3: begin
                  if (op_ff != OP_STOP) begin
                     scl_ff <= 1'b0;
                  end
                  bitCnt_ff <= bitCnt_ff + 4'h1;
                  if (lastBit) begin
                     hst_ff <= HS_IDLE;
                     if (op_ff == OP_WRITE) begin
                        ackSeen_ff <= ~sh_ff[0];
                     end else if (op_ff == OP_READ) begin
                        rxData_ff <= sh_ff[8:1];
                     end
                  end
               end
            endcase
         end
      end
   end

   assign link.scl        = scl_ff;
   assign link.sdaHostOut = 1'b0;
   assign link.sdaHostOeN = sdaOeN_ff;

endmodule

// *** dv/dpc_link_sva.sv ***
// Checker for the two-wire link between the bus master and the pot slave.
// Assumes the interface signals are fed in directly, no bind.
`timescale 1ns/100ps
module dpc_link_sva (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Link
   input wire logic scl,
   input wire logic sdaHostOut,
   input wire logic sdaHostOeN,
   input wire logic sdaDevOut,
   input wire logic sdaDevOeN,
   input wire logic sda
);
   // ****************************************
   // Link properties
   // ****************************************
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);

   a_open_drain: assert property (!sdaHostOut && !sdaDevOut)
      else $error("data line driven high");
   a_reset_idle: assert property ($past(rst) |-> scl && sdaHostOeN && sdaDevOeN)
      else $error("link not idle after reset");
   a_scl_high: assert property ($rose(scl) |-> scl [*8])
      else $error("clock high phase too short");
   a_scl_low: assert property ($fell(scl) |-> !scl [*8])
      else $error("clock low phase too short");
   a_dev_scl_low: assert property ($changed(sdaDevOeN) |-> !scl)
      else $error("slave moved data while clock high");
   a_start_by_host: assert property (scl && $past(scl) && $fell(sda) |-> !sdaHostOeN)
      else $error("start not made by master");
   a_stop_by_host: assert property (scl && $past(scl) && $rose(sda) |-> $rose(sdaHostOeN))
      else $error("stop not made by master");
   a_dev_hold: assert property ($fell(sdaDevOeN) |-> !sdaDevOeN [*8])
      else $error("slave bit too short");
   a_dev_release: assert property ($fell(sdaDevOeN) |-> ##[1:200] $rose(sdaDevOeN))
      else $error("slave never released data");

   c_start: cover property (scl && $past(scl) && $fell(sda));
   c_stop: cover property (scl && $past(scl) && $rose(sda));
   c_dev_drive: cover property ($fell(sdaDevOeN));
endmodule

// *** dv/pot_slave_addressing_and_wiper_control_tb.sv ***
// Testbench joining the bus master and the pot slave over the link.
// Assumes the master is commanded over classic Wishbone only.
`timescale 1ns/100ps
`define CHK(nm, ex, gt) begin nCompared++; if ((gt) !== (ex)) begin fails++; \
   $display("mismatch %s exp %h got %h", nm, ex, gt); end end
module pot_slave_addressing_and_wiper_control_tb;
   import dpc_pkg::*;
   typedef struct {logic [7:0] a; logic k;} dpc_row_s;
   typedef struct {logic [1:0] s; logic [7:0] d; logic [7:0] e;} dpc_wr_s;
   logic         clk_sys, rst, supplyOk, wbCyc, wbStb, wbWe, wbAck, writeBusy, ak, aa, ia;
   logic [3:0]   wbAdr;
   logic [31:0]  wbDatI, wbDatO;
   logic [7:0]   rx;
   logic [63:0]  tapEn0;
   logic [99:0]  tapEn1;
   logic [255:0] tapEn2;
   int           fails, nCompared, n;
   dpc_row_s     rows [8] = '{'{8'ha0, 1'b1}, '{8'ha4, 1'b1}, '{8'hae, 1'b1}, '{8'hb0, 1'b0},
                              '{8'ha2, 1'b0}, '{8'ha8, 1'b0}, '{8'h2e, 1'b0}, '{8'hac, 1'b0}};
   dpc_wr_s      wr [5] = '{'{2'h0, 8'h10, 8'h10}, '{2'h1, 8'h70, 8'h63},
                            '{2'h2, 8'hab, 8'hab}, '{2'h1, 8'h63, 8'h63}, '{2'h0, 8'h50, 8'h3f}};

   dpc_link_if i_dpc_link_if ();
   dpc_pot_slave #(.WRITE_CYC_P(400), .PURST_CYC_P(100)) i_dpc_pot_slave (.clk_sys(clk_sys),
      .rst(rst), .link(i_dpc_link_if), .supplyOk(supplyOk), .tapEn0(tapEn0), .tapEn1(tapEn1),
      .tapEn2(tapEn2), .writeBusy(writeBusy));
   dpc_bus_master i_dpc_bus_master (.clk_sys(clk_sys), .rst(rst), .link(i_dpc_link_if),
      .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(4'hf),
      .wb_dat_i(wbDatI), .wb_dat_o(wbDatO), .wb_ack_o(wbAck));
   dpc_link_sva i_dpc_link_sva (.clk_sys(clk_sys), .rst(rst), .scl(i_dpc_link_if.scl),
      .sdaHostOut(i_dpc_link_if.sdaHostOut), .sdaHostOeN(i_dpc_link_if.sdaHostOeN),
      .sdaDevOut(i_dpc_link_if.sdaDevOut), .sdaDevOeN(i_dpc_link_if.sdaDevOeN),
      .sda(i_dpc_link_if.sda));

   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end

   // ****************************************
   // Bus and link tasks
   // ****************************************
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] q);
      @(posedge clk_sys);
      wbCyc <= 1'b1;
      wbStb <= 1'b1;
      wbWe <= w;
      wbAdr <= a;
      wbDatI <= d;
      do @(posedge clk_sys); while (wbAck !== 1'b1);
      q = wbDatO;
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
   endtask

   task automatic op(input dpc_op_e c, input logic [7:0] b = 8'h0, input logic nk = 1'b0);
      logic [31:0] q;
      wb(1'b1, ADR_TX, {24'h0, b}, q);
      wb(1'b1, ADR_CMD, {29'h0, nk, c}, q);
      do wb(1'b0, ADR_STAT, 32'h0, q); while (q[STAT_BUSY_BIT] !== 1'b0);
      ak = q[STAT_ACK_BIT];
      rx = q[STAT_RX_LSB +: 8];
   endtask

   task automatic rdAdr(input logic [7:0] a);
      op(OP_START);
      op(OP_WRITE, a);
      aa = ak;
      if (aa === 1'b1) op(OP_READ, 8'h0, 1'b1);
      op(OP_STOP);
   endtask

   task automatic potWr(input logic [1:0] s, input logic t, input logic [7:0] d);
      op(OP_START);
      op(OP_WRITE, 8'hae);
      op(OP_WRITE, {t, 5'h0, s});
      ia = ak;
      if (ia === 1'b1) op(OP_WRITE, d);
      op(OP_STOP);
   endtask

   task automatic potRd(input logic [1:0] s, input logic t);
      op(OP_START);
      op(OP_WRITE, 8'hae);
      op(OP_WRITE, {t, 5'h0, s});
      rdAdr(8'haf);
   endtask

   task automatic end_of_test;
      $display("compared %0d mismatches %0d", nCompared, fails);
      if (fails == 0 && nCompared > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      {rst, supplyOk, wbCyc, wbStb, wbWe, wbAdr, wbDatI} = {1'b1, 40'h0};
      repeat (20) @(posedge clk_sys);
      rst <= 1'b0;
      repeat (3) @(posedge clk_sys);
      `CHK("tap0", {1'b1, 63'h0}, tapEn0)
      `CHK("tap1", 100'h1, tapEn1)
      `CHK("tap2", {1'b1, 255'h0}, tapEn2)
      supplyOk <= 1'b1;
      repeat (60) @(posedge clk_sys);
      `CHK("early", {1'b1, 63'h0}, tapEn0)
      repeat (100) @(posedge clk_sys);
      `CHK("recall0", 64'h1, tapEn0)
      `CHK("recall2", 256'h1, tapEn2)
      foreach (rows[i]) begin
         op(OP_START);
         op(OP_WRITE, rows[i].a);
         `CHK("addrAck", rows[i].k, ak)
         op(OP_STOP);
      end
      potWr(2'h0, 1'b0, 8'h10);
      `CHK("noLatch", 64'h1, tapEn0)
      op(OP_START);
      op(OP_WRITE, 8'ha4);
      op(OP_WRITE, 8'h01);
      op(OP_STOP);
      rdAdr(8'ha5);
      `CHK("csrRead", 8'h01, rx)
      foreach (wr[i]) begin
         potWr(wr[i].s, 1'b0, wr[i].d);
         potRd(wr[i].s, 1'b1);
         `CHK("wiper", wr[i].e, rx)
      end
      `CHK("clamp0", {1'b1, 63'h0}, tapEn0)
      potWr(2'h2, 1'b1, 8'h5a);
      `CHK("busy", 1'b1, writeBusy)
      op(OP_START);
      op(OP_WRITE, 8'hae);
      `CHK("busyNack", 1'b0, ak)
      op(OP_STOP);
      n = 0;
      while (writeBusy !== 1'b0 && n < 2000) begin
         @(posedge clk_sys);
         n++;
      end
      `CHK("busyEnd", 1'b0, writeBusy)
      rdAdr(8'haf);
      `CHK("pollAck", 1'b1, aa)
      `CHK("nvRead", 8'h5a, rx)
      potWr(2'h2, 1'b0, 8'h11);
      potWr(2'h0, 1'b0, 8'h22);
      potRd(2'h2, 1'b1);
      `CHK("typeIgnored", 8'h11, rx)
      potWr(2'h3, 1'b0, 8'h01);
      `CHK("reserved", 1'b0, ia)
      supplyOk <= 1'b0;
      repeat (10) @(posedge clk_sys);
      `CHK("dropInit", {1'b1, 63'h0}, tapEn0)
      supplyOk <= 1'b1;
      repeat (160) @(posedge clk_sys);
      `CHK("nvKept", 256'h1 << 8'h5a, tapEn2)
      `CHK("volLost", 64'h1, tapEn0)
      end_of_test;
   end

   initial begin
      repeat (80000) @(posedge clk_sys);
      fails++;
      end_of_test;
   end
endmodule
